// ===== vibration_suppress_speed_select.sv
// low-frequency vibration suppression settings with auto search, and preset speed selection
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`include "vs_defs.svh"
module vibration_suppress_speed_select
  import vs_pkg::*;
#(
  parameter int TICK_CYC = `VS_TICK_CYC,
  parameter int WIN_TICKS = `VS_WIN_TICKS
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire reg_req_s i_bus,
  input wire logic i_speed_select_lo,
  input wire logic i_speed_select_hi,
  input wire logic i_torque_mode,
  input wire logic signed [15:0] i_pos_err,
  output logic [31:0] o_rdata,
  output logic o_suppress_en_a,
  output logic o_suppress_en_b,
  output logic [15:0] o_suppress_freq_a,
  output logic [15:0] o_suppress_freq_b,
  output logic [15:0] o_suppress_gain_a,
  output logic [15:0] o_suppress_gain_b,
  output logic o_searching,
  output logic o_inertia_est_en,
  output logic signed [31:0] o_speed_cmd,
  output logic [31:0] o_speed_limit
);
  logic [15:0] freq_a_r, freq_b_r, gain_a_r, gain_b_r, level_r;
  logic signed [31:0] preset_r [3];
  logic tuning_auto_r;
  search_e state_r;
  logic [31:0] tick_cnt_r, win_cnt_r;
  logic tick, win_end;
  logic [15:0] cross_cnt_r, prev_est_r, peak_r;
  logic [3:0] agree_r;
  logic [7:0] win_left_r;
  logic prev_neg_r;
  // bus decode
  wire wr_freq_a = i_bus.wr && (i_bus.addr == `VS_ADDR_FREQ_A);
  wire wr_freq_b = i_bus.wr && (i_bus.addr == `VS_ADDR_FREQ_B);
  wire wr_gain_a = i_bus.wr && (i_bus.addr == `VS_ADDR_GAIN_A);
  wire wr_gain_b = i_bus.wr && (i_bus.addr == `VS_ADDR_GAIN_B);
  wire wr_auto = i_bus.wr && (i_bus.addr == `VS_ADDR_AUTO);
  wire wr_level = i_bus.wr && (i_bus.addr == `VS_ADDR_LEVEL);
  wire wr_tuning = i_bus.wr && (i_bus.addr == `VS_ADDR_TUNING);
  wire [15:0] wfreq = i_bus.wdata[15:0];
  wire freq_ok = (wfreq >= `VS_FREQ_MIN) && (wfreq <= `VS_FREQ_MAX);
  wire signed [31:0] wspeed = i_bus.wdata;
  wire speed_ok = (wspeed >= $signed(`VS_SPEED_MIN)) && (wspeed <= $signed(`VS_SPEED_MAX));
  wire searching = (state_r != ST_IDLE);
  wire start_search = wr_auto && i_bus.wdata[0] && tuning_auto_r && !searching;
  wire abort_search = searching && ((wr_auto && !i_bus.wdata[0]) || (wr_tuning && !i_bus.wdata[0]));
  // frequency estimator: rising zero crossings counted over a 10 s window give 0.1 Hz units
  assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));
  assign win_end = tick && (win_cnt_r == 32'(WIN_TICKS - 1));
  wire now_neg = i_pos_err[15];
  wire [15:0] mag = now_neg ? 16'(-i_pos_err) : i_pos_err;
  wire crossing = tick && (prev_neg_r != now_neg);
  wire big_enough = (peak_r >= level_r);
  wire count_it = crossing && !now_neg && big_enough;
  wire [15:0] est = cross_cnt_r;
  wire [15:0] est_diff = (est > prev_est_r) ? est - prev_est_r : prev_est_r - est;
  wire est_valid = (est >= `VS_FREQ_MIN) && (est <= `VS_FREQ_MAX);
  wire agree_now = est_valid && (est_diff <= 16'h0001);
  wire steady_hit = win_end && agree_now && (agree_r == `VS_STEADY_CNT - 4'h1);
  wire [15:0] est_vs_a = (est > freq_a_r) ? est - freq_a_r : freq_a_r - est;
  wire distinct = (est_vs_a > 16'h0001);
  wire found_a = (state_r == ST_FIRST) && steady_hit;
  wire found_b = (state_r == ST_SECOND) && steady_hit && distinct;
  wire give_up = win_end && (win_left_r == 8'h01) && !found_a && !found_b;
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 32'h0000_0001;
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n || !searching)
    begin
      win_cnt_r <= '0;
      cross_cnt_r <= '0;
      prev_est_r <= '0;
      agree_r <= '0;
      peak_r <= '0;
      prev_neg_r <= 1'b0;
    end
    else if (tick)
    begin
      prev_neg_r <= now_neg;
      peak_r <= crossing ? mag : ((mag > peak_r) ? mag : peak_r);
      win_cnt_r <= win_end ? '0 : win_cnt_r + 32'h0000_0001;
      if (win_end)
      begin
        cross_cnt_r <= '0;
        prev_est_r <= est;
        agree_r <= (agree_now && !steady_hit) ? agree_r + 4'h1 : 4'h0;
      end
      else if (count_it)
        cross_cnt_r <= cross_cnt_r + 16'h0001;
    end
  end
  // search sequencer
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      state_r <= ST_IDLE;
      win_left_r <= '0;
    end
    else if (abort_search)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (start_search)
          begin
            state_r <= ST_FIRST;
            win_left_r <= `VS_MAX_WIN;
          end
        end
        ST_FIRST:
        begin
          if (found_a)
          begin
            state_r <= ST_SECOND;
            win_left_r <= `VS_SECOND_WIN;
          end
          else if (give_up)
            state_r <= ST_IDLE;
          else if (win_end)
            win_left_r <= win_left_r - 8'h01;
        end
        ST_SECOND:
        begin
          if (found_b || give_up)
            state_r <= ST_IDLE;
          else if (win_end)
            win_left_r <= win_left_r - 8'h01;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end
  // suppression set registers; search results win over a software write in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      freq_a_r <= `VS_FREQ_RST;
      freq_b_r <= `VS_FREQ_RST;
      gain_a_r <= `VS_GAIN_RST;
      gain_b_r <= `VS_GAIN_RST;
      level_r <= `VS_LEVEL_RST;
      tuning_auto_r <= 1'b0;
    end
    else
    begin
      if (wr_freq_a && freq_ok)
        freq_a_r <= wfreq;
      if (wr_freq_b && freq_ok)
        freq_b_r <= wfreq;
      if (wr_gain_a)
        gain_a_r <= i_bus.wdata[15:0];
      if (wr_gain_b)
        gain_b_r <= i_bus.wdata[15:0];
      if (wr_level)
        level_r <= i_bus.wdata[15:0];
      if (wr_tuning)
        tuning_auto_r <= i_bus.wdata[0];
      if (start_search)
      begin
        gain_a_r <= `VS_GAIN_RST;
        gain_b_r <= `VS_GAIN_RST;
      end
      if (found_a)
      begin
        freq_a_r <= est;
        gain_a_r <= `VS_GAIN_FOUND;
      end
      if (found_b)
      begin
        freq_b_r <= est;
        gain_b_r <= `VS_GAIN_FOUND;
      end
    end
  end
  // preset speeds may be rewritten at any time, also while running
  genvar p;
  generate
    for (p = 0; p < 3; p++)
    begin : g_preset
      wire hit = i_bus.wr && (i_bus.addr == 8'(`VS_ADDR_PRESET_2 + 4 * p));
      always_ff @(posedge i_clk)
      begin
        if (!i_reset_n)
          preset_r[p] <= '0;
        else if (hit && speed_ok)
          preset_r[p] <= wspeed;
      end
    end
  endgenerate
  // speed selection is purely combinational so a select change reaches the s-curve target at once
  wire [1:0] sel = {i_speed_select_hi, i_speed_select_lo};
  wire signed [31:0] target = (sel == 2'b00) ? 32'sh0000_0000 : preset_r[sel - 2'b01];
  speed_s_curve u_s_curve
  (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_tick(tick),
    .i_target(target),
    .o_cmd(o_speed_cmd)
  );
  wire [31:0] cmd_mag = o_speed_cmd[31] ? 32'(-o_speed_cmd) : 32'(o_speed_cmd);
  wire [31:0] status = {28'h000_0000, tuning_auto_r, i_torque_mode, sel == 2'b00, searching};
  wire [31:0] rd_mux =
    (i_bus.addr == `VS_ADDR_FREQ_A) ? {16'h0000, freq_a_r} :
    (i_bus.addr == `VS_ADDR_GAIN_A) ? {16'h0000, gain_a_r} :
    (i_bus.addr == `VS_ADDR_FREQ_B) ? {16'h0000, freq_b_r} :
    (i_bus.addr == `VS_ADDR_GAIN_B) ? {16'h0000, gain_b_r} :
    (i_bus.addr == `VS_ADDR_AUTO) ? {31'h0000_0000, searching} :
    (i_bus.addr == `VS_ADDR_LEVEL) ? {16'h0000, level_r} :
    (i_bus.addr == `VS_ADDR_PRESET_2) ? preset_r[0] :
    (i_bus.addr == `VS_ADDR_PRESET_3) ? preset_r[1] :
    (i_bus.addr == `VS_ADDR_PRESET_4) ? preset_r[2] :
    (i_bus.addr == `VS_ADDR_TUNING) ? {31'h0000_0000, tuning_auto_r} :
    (i_bus.addr == `VS_ADDR_STATUS) ? status :
    (i_bus.addr == `VS_ADDR_SPEED_CMD) ? o_speed_cmd : 32'h0000_0000;
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_rdata <= '0;
      o_speed_limit <= '0;
    end
    else
    begin
      o_rdata <= i_bus.rd ? rd_mux : 32'h0000_0000;
      o_speed_limit <= i_torque_mode ? cmd_mag : 32'h0000_0000;
    end
  end
  // a set only acts with nonzero gain and never while the search is listening
  assign o_suppress_en_a = (gain_a_r != 16'h0000) && !searching;
  assign o_suppress_en_b = (gain_b_r != 16'h0000) && !searching;
  assign o_suppress_freq_a = freq_a_r;
  assign o_suppress_freq_b = freq_b_r;
  assign o_suppress_gain_a = gain_a_r;
  assign o_suppress_gain_b = gain_b_r;
  assign o_searching = searching;
  assign o_inertia_est_en = tuning_auto_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence start_seq;
    start_search ##1 (state_r == ST_FIRST);
  endsequence
  freq_band_a: assert property (freq_a_r >= `VS_FREQ_MIN && freq_a_r <= `VS_FREQ_MAX)
    else $error("set a frequency out of band");
  bad_freq_kept_a: assert property (wr_freq_b && !freq_ok && !found_b |=> $stable(freq_b_r))
    else $error("out of band frequency accepted");
  search_start_a: assert property (start_seq |-> !o_suppress_en_a && gain_a_r == 16'h0000)
    else $error("search start did not stop suppression");
  first_found_a: assert property (found_a |=> gain_a_r == 16'h0001 && freq_a_r == $past(est))
    else $error("first frequency not stored");
  second_found_a: assert property (found_b |=> gain_b_r == 16'h0001 && !searching)
    else $error("second frequency not stored");
  level_gate_a: assert property
    (crossing && !big_enough && !win_end |=> $stable(cross_cnt_r))
    else $error("small oscillation counted");
  gain_zero_off_a: assert property (gain_b_r == 16'h0000 |-> !o_suppress_en_b)
    else $error("zero gain set still active");
  select_map_a: assert property (target == ((sel == 2'b00) ? 32'sh0000_0000 :
    (sel == 2'b01) ? preset_r[0] : (sel == 2'b10) ? preset_r[1] : preset_r[2]))
    else $error("wrong speed source");
  preset_range_a: assert property (preset_r[1] >= $signed(`VS_SPEED_MIN))
    else $error("preset below range");
  torque_limit_a: assert property (i_torque_mode |=> o_speed_limit == $past(cmd_mag))
    else $error("speed limit not the selected command");
  manual_stop_a: assert property
    (wr_tuning && !i_bus.wdata[0] |=> !searching && !o_inertia_est_en)
    else $error("manual tuning left automatic functions on");
endmodule : vibration_suppress_speed_select

// ===== vs_defs.svh
// register map, field limits, reset values and timing constants of the command-side block
`ifndef VS_DEFS_SVH
`define VS_DEFS_SVH
`define VS_ADDR_W 8
`define VS_ADDR_FREQ_A 8'h00
`define VS_ADDR_GAIN_A 8'h04
`define VS_ADDR_FREQ_B 8'h08
`define VS_ADDR_GAIN_B 8'h0C
`define VS_ADDR_AUTO 8'h10
`define VS_ADDR_LEVEL 8'h14
`define VS_ADDR_PRESET_2 8'h18
`define VS_ADDR_PRESET_3 8'h1C
`define VS_ADDR_PRESET_4 8'h20
`define VS_ADDR_TUNING 8'h24
`define VS_ADDR_STATUS 8'h28
`define VS_ADDR_SPEED_CMD 8'h2C
`define VS_FREQ_MIN 16'h000A
`define VS_FREQ_MAX 16'h03E8
`define VS_FREQ_RST 16'h03E8
`define VS_GAIN_RST 16'h0000
`define VS_GAIN_FOUND 16'h0001
`define VS_LEVEL_RST 16'h0064
`define VS_SPEED_MIN 32'hFFFF_15A0
`define VS_SPEED_MAX 32'h0000_EA60
`define VS_RAMP_STEP 32'h0000_0064
`define VS_CLK_HZ 25000000
`define VS_TICK_US 1000
`define VS_TICK_CYC ((`VS_CLK_HZ / 1000000) * `VS_TICK_US)
`define VS_WIN_S 10
`define VS_WIN_TICKS (`VS_WIN_S * 1000000 / `VS_TICK_US)
`define VS_STEADY_CNT 4'h3
`define VS_MAX_WIN 8'h10
`define VS_SECOND_WIN 8'h08
`endif

// ===== vs_pkg.sv
// types shared by the vibration suppression and speed select logic
package vs_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
  typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_SECOND} search_e;
endpackage : vs_pkg

// ===== speed_s_curve.sv
// s-curve smoothing of the speed command: slew limiter followed by a moving average
`include "vs_defs.svh"
module speed_s_curve
  import vs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_tick,
  input wire logic signed [31:0] i_target,
  output logic signed [31:0] o_cmd
);
  localparam int TAPS = 4;
  logic signed [31:0] ramp_r;
  logic signed [31:0] hist_r [TAPS];
  logic signed [31:0] ramp_nxt;
  logic signed [33:0] sum;
  logic signed [31:0] diff;
  // the slew limit gives a trapezoid; averaging rounds its corners into an s shape
  assign diff = i_target - ramp_r;
  assign ramp_nxt = (diff > $signed(`VS_RAMP_STEP)) ? ramp_r + $signed(`VS_RAMP_STEP) :
                    (diff < -$signed(`VS_RAMP_STEP)) ? ramp_r - $signed(`VS_RAMP_STEP) :
                    i_target;
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      ramp_r <= '0;
    else if (i_tick)
      ramp_r <= ramp_nxt;
  end
  genvar g;
  generate
    for (g = 0; g < TAPS; g++)
    begin : g_hist
      always_ff @(posedge i_clk)
      begin
        if (!i_reset_n)
          hist_r[g] <= '0;
        else if (i_tick)
          hist_r[g] <= (g == 0) ? ramp_r : hist_r[(g == 0) ? 0 : g - 1];
      end
    end
  endgenerate
  assign sum = 34'(hist_r[0]) + 34'(hist_r[1]) + 34'(hist_r[2]) + 34'(hist_r[3]);
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_cmd <= '0;
    else
      o_cmd <= 32'(sum >>> 2);
  end
endmodule : speed_s_curve

// ===== motion_partner.sv
// motion controller model: square position error oscillation around rest
module motion_partner (
  input wire logic i_clk,
  input wire logic i_osc_en,
  input wire logic [15:0] i_amp,
  output logic signed [15:0] o_pos_err
);
  timeunit 1ns;
  timeprecision 1ps;
  int half_cnt = 0;
  logic phase = 1'b0;
  // half period of 8 cycles, two ticks at the bench tick length
  always @(posedge i_clk)
  begin
    half_cnt <= (half_cnt == 7) ? 0 : half_cnt + 1;
    if (half_cnt == 7)
    begin
      phase <= ~phase;
    end
  end
  assign o_pos_err = !i_osc_en ? 16'sh0000 : (phase ? -$signed(i_amp) : $signed(i_amp));
endmodule : motion_partner

// ===== vibration_suppress_speed_select_tb_top.sv
// self-checking bench for the vibration suppression and speed select block
`include "vs_defs.svh"
module vibration_suppress_speed_select_tb_top
  import vs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  // twelve rising crossings per window keep the estimate inside the accepted band
  localparam int WIN = 48;
  localparam int EST = WIN / 4;
  localparam logic [7:0] FADR [4] = '{`VS_ADDR_FREQ_A, `VS_ADDR_FREQ_A, `VS_ADDR_FREQ_B,
    `VS_ADDR_FREQ_B};
  localparam logic [31:0] FVAL [4] = '{32'h0000_0009, 32'h0000_000A, 32'h0000_03E9, 32'h0000_0064};
  localparam logic [31:0] FEXP [4] = '{32'h0000_03E8, 32'h0000_000A, 32'h0000_03E8, 32'h0000_0064};
  localparam logic [31:0] SPD [4] = '{32'h0000_0000, 32'h0000_012C, 32'hFFFF_FF38, 32'h0000_01F4};
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  reg_req_s i_bus = '0;
  logic sel_lo = 1'b0;
  logic sel_hi = 1'b0;
  logic torque = 1'b0;
  logic osc_en = 1'b0;
  logic [15:0] amp = 16'h0200;
  logic signed [15:0] pos_err;
  logic [31:0] o_rdata;
  logic [31:0] o_speed_limit;
  logic en_a, en_b, searching, est_en;
  logic [15:0] fa, fb, ga, gb;
  logic signed [31:0] speed_cmd;
  logic [31:0] rd_val;
  int fails = 0;
  int samples_checked = 0;

  always #20 i_clk = ~i_clk;

  vibration_suppress_speed_select #(.TICK_CYC(TICK), .WIN_TICKS(WIN)) DUT (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_bus(i_bus),
    .i_speed_select_lo(sel_lo), .i_speed_select_hi(sel_hi), .i_torque_mode(torque),
    .i_pos_err(pos_err), .o_rdata(o_rdata), .o_suppress_en_a(en_a), .o_suppress_en_b(en_b),
    .o_suppress_freq_a(fa), .o_suppress_freq_b(fb), .o_suppress_gain_a(ga),
    .o_suppress_gain_b(gb), .o_searching(searching), .o_inertia_est_en(est_en),
    .o_speed_cmd(speed_cmd), .o_speed_limit(o_speed_limit));

  motion_partner ctrl (.i_clk(i_clk), .i_osc_en(osc_en), .i_amp(amp), .o_pos_err(pos_err));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    i_bus.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    i_bus.rd <= 1'b0;
    #1;
    rd_val = o_rdata;
    chk(name, exp, rd_val);
  endtask : rchk

  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge i_clk);
    #1;
  endtask : ticks

  // bounded wait: a search never outlasts its window limit
  task automatic wait_search_end;
    int n;
    n = 0;
    while (searching === 1'b1 && n < 4000)
    begin
      @(posedge i_clk);
      n++;
    end
    #1;
  endtask : wait_search_end

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (20000) @(posedge i_clk);
    fails++;
    conclude();
  end

  initial
  begin
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rchk("gain_a", `VS_ADDR_GAIN_A, 32'h0000_0000);
    rchk("gain_b", `VS_ADDR_GAIN_B, 32'h0000_0000);
    rchk("unmapped", 8'hFC, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      wr(FADR[i], FVAL[i]);
      rchk("freq", FADR[i], FEXP[i]);
    end
    rchk("freq_a kept", `VS_ADDR_FREQ_A, 32'h0000_000A);
    chk("freq_b out", 32'h0000_0064, fb);
    chk("freq_a out", 32'h0000_000A, fa);
    wr(`VS_ADDR_GAIN_A, 32'h0000_0002);
    chk("en_a on", 1'b1, en_a);
    chk("en_b off", 1'b0, en_b);
    wr(`VS_ADDR_GAIN_A, 32'h0000_0000);
    chk("en_a off", 1'b0, en_a);
    $display("test suppression settings done");
    wr(`VS_ADDR_PRESET_2, 32'hFFFF_15A0);
    rchk("preset min", `VS_ADDR_PRESET_2, 32'hFFFF_15A0);
    wr(`VS_ADDR_PRESET_2, 32'h0000_EA61);
    rchk("preset over", `VS_ADDR_PRESET_2, 32'hFFFF_15A0);
    wr(`VS_ADDR_PRESET_2, SPD[1]);
    wr(`VS_ADDR_PRESET_3, SPD[2]);
    wr(`VS_ADDR_PRESET_4, SPD[3]);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge i_clk);
      sel_hi <= s[1];
      sel_lo <= s[0];
      repeat (3) @(posedge i_clk);
      #1;
      if (s > 0)
        chk("smoothed step", 1'b1, speed_cmd !== SPD[s]);
      ticks(40);
      chk("speed_cmd", SPD[s], speed_cmd);
      rchk("status", `VS_ADDR_STATUS, (s == 0) ? 32'h0000_0002 : 32'h0000_0000);
      chk("sel_zero", s == 0, rd_val[1]);
    end
    wr(`VS_ADDR_PRESET_4, 32'h0000_02BC);
    ticks(40);
    chk("live preset", 32'h0000_02BC, speed_cmd);
    chk("limit idle", 32'h0000_0000, o_speed_limit);
    @(posedge i_clk);
    torque <= 1'b1;
    ticks(2);
    chk("speed limit", 32'h0000_02BC, o_speed_limit);
    $display("test speed select done");
    wr(`VS_ADDR_TUNING, 32'h0000_0000);
    wr(`VS_ADDR_AUTO, 32'h0000_0001);
    chk("manual no search", 1'b0, searching);
    chk("manual no est", 1'b0, est_en);
    wr(`VS_ADDR_TUNING, 32'h0000_0001);
    chk("auto est", 1'b1, est_en);
    wr(`VS_ADDR_LEVEL, 32'h0000_1000);
    wr(`VS_ADDR_GAIN_A, 32'h0000_0003);
    osc_en <= 1'b1;
    wr(`VS_ADDR_AUTO, 32'h0000_0001);
    chk("searching", 1'b1, searching);
    chk("gain_a cleared", 16'h0000, ga);
    chk("en_a stopped", 1'b0, en_a);
    wait_search_end();
    chk("end", 1'b0, searching);
    chk("none a", 16'h0000, ga);
    chk("none b", 16'h0000, gb);
    rchk("auto idle", `VS_ADDR_AUTO, 32'h0000_0000);
    wr(`VS_ADDR_LEVEL, 32'h0000_0100);
    wr(`VS_ADDR_AUTO, 32'h0000_0001);
    wait_search_end();
    chk("found gain_a", `VS_GAIN_FOUND, ga);
    chk("freq_a near", 1'b1, fa >= EST - 1 && fa <= EST + 1);
    chk("single gain_b", 16'h0000, gb);
    chk("freq_b kept", 32'h0000_0064, fb);
    chk("en_a found", 1'b1, en_a);
    rchk("auto cleared", `VS_ADDR_AUTO, 32'h0000_0000);
    $display("test auto search done");
    conclude();
  end
endmodule : vibration_suppress_speed_select_tb_top
